/* rtl/cbt_params.svh */
// Purpose : Constants for the CAN controller setup and bit timing block
// Assumes : Included by bare name from rtl files
// Notes   : Offsets are word indexes of the indexed register space
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// ***********************************************
// Indexed register space
// ***********************************************
`define CBT_IDX_CONTROL     7'h00
`define CBT_IDX_STATUS      7'h01
`define CBT_IDX_BIT_TIMING  7'h03
`define CBT_IDX_TEST        7'h05
`define CBT_IDX_PRESC_EXT   7'h06
`define CBT_IDX_SET1_CMDREQ 7'h08
`define CBT_IDX_SET2_CMDREQ 7'h20
`define CBT_IDX_VALID_LO    7'h30
`define CBT_IDX_VALID_HI    7'h31
`define CBT_IDX_NEWDAT_LO   7'h32
`define CBT_IDX_NEWDAT_HI   7'h33
`define CBT_IDX_TXREQ_LO    7'h34
`define CBT_IDX_TXREQ_HI    7'h35

// ***********************************************
// Direct register select
// ***********************************************
`define CBT_DIR_CONTROL     2'h0
`define CBT_DIR_STATUS      2'h1
`define CBT_DIR_TEST        2'h2

// ***********************************************
// Field positions
// ***********************************************
`define CBT_CTL_INIT        0
`define CBT_CTL_CFGEN       6
`define CBT_CTL_TEST        7
`define CBT_BT_PRESC_LSB    0
`define CBT_BT_JUMP_LSB     6
`define CBT_BT_SEGONE_LSB   8
`define CBT_BT_SEGTWO_LSB   12
`define CBT_TST_RX          7

// ***********************************************
// Reset values
// ***********************************************
`define CBT_RST_CONTROL     16'h0001
`define CBT_RST_BIT_TIMING  16'h2301
`define CBT_RST_PRESC_EXT   16'h0000
`define CBT_RST_TEST        16'h0000
`define CBT_SYNC_SEG_TQ     4'h1

`endif

/* rtl/cbt_pkg.sv */
// Purpose : Types for the CAN controller setup and bit timing block
// Assumes : None
// Notes   : Constants live in cbt_params.svh
package cbt_pkg;
    typedef logic [15:0] cbt_word_t;
    typedef logic [6:0]  cbt_index_t;
    typedef enum logic [1:0] {
        CBT_SEG_SYNC  = 2'b00,
        CBT_SEG_ONE   = 2'b01,
        CBT_SEG_TWO   = 2'b10
    } cbt_seg_t;
endpackage

/* rtl/cbt_bit_timer.sv */
// Purpose : Quantum prescaler and bit segment sequencer
// Assumes : Fields already hold length minus one
// Notes   : Emits a sample strobe at the end of the first segment
`include "cbt_params.svh"
`timescale 1ns/10ps
`default_nettype none
module cbt_bit_timer
    import cbt_pkg::*;
(
    input  wire logic       mclk,        // System clock
    input  wire logic       reset,       // Async reset, active high
    input  wire logic       runEn,       // Timing runs while high
    input  wire logic [9:0] baudPrescM1, // Prescaler minus one
    input  wire logic [3:0] segOneM1,    // First segment minus one
    input  wire logic [2:0] segTwoM1,    // Second segment minus one
    output logic            tqTick,      // One pulse per quantum
    output logic            samplePt,    // Pulse at sample point
    output logic            bitEnd       // Pulse at end of bit
);
    logic [9:0] preCnt_reg, preCnt_next;
    logic [3:0] segCnt_reg, segCnt_next;
    cbt_seg_t   seg_reg, seg_next;
    logic       tq;

    assign tq = runEn && (preCnt_reg == baudPrescM1);
    assign tqTick = tq;

    // ***********************************************
    // Segment sequencing
    // ***********************************************
    always_comb begin
        preCnt_next = runEn ? (tq ? 10'h000 : preCnt_reg + 10'h001) : 10'h000;
        segCnt_next = segCnt_reg;
        seg_next    = seg_reg;
        samplePt    = 1'b0;
        bitEnd      = 1'b0;
        if (!runEn) begin
            segCnt_next = 4'h0;
            seg_next    = CBT_SEG_SYNC;
        end else if (tq) begin
            case (seg_reg)
                CBT_SEG_SYNC: begin
                    seg_next    = CBT_SEG_ONE;
                    segCnt_next = 4'h0;
                end
                CBT_SEG_ONE: begin
                    if (segCnt_reg == segOneM1) begin
                        seg_next    = CBT_SEG_TWO;
                        segCnt_next = 4'h0;
                        samplePt    = 1'b1;
                    end else begin
                        segCnt_next = segCnt_reg + 4'h1;
                    end
                end
                CBT_SEG_TWO: begin
                    if (segCnt_reg[2:0] == segTwoM1) begin
                        seg_next    = CBT_SEG_SYNC;
                        segCnt_next = 4'h0;
                        bitEnd      = 1'b1;
                    end else begin
                        segCnt_next = segCnt_reg + 4'h1;
                    end
                end
                default: begin
                    seg_next = CBT_SEG_SYNC;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            preCnt_reg <= 10'h000;
            segCnt_reg <= 4'h0;
            seg_reg    <= CBT_SEG_SYNC;
        end else begin
            preCnt_reg <= preCnt_next;
            segCnt_reg <= segCnt_next;
            seg_reg    <= seg_next;
        end
    end

    // ***********************************************
    // Checks
    // ***********************************************
    chk_sync_one_tq: assert property (@(posedge mclk) disable iff (reset)
        (seg_reg == CBT_SEG_SYNC && tq) |=> (seg_reg == CBT_SEG_ONE))
        else $error("sync segment longer than one quantum");
    chk_tq_spacing: assert property (@(posedge mclk) disable iff (reset)
        (tq && baudPrescM1 == 10'h001 && $stable(baudPrescM1) && runEn) |=> !tq)
        else $error("quantum tick too early");
endmodule
`default_nettype wire

/* rtl/cbt_can_core.sv */
// Purpose : CAN controller setup, indexed registers and bit timing
// Assumes : Core bus strobes are single cycle and synchronous to mclk
// Notes   : Protocol engine reduced to a bit-level shifter of object data
//
// Functional notes
// - Thirty-two message objects held in a dedicated message RAM.
// - Core shifts frames out on transmit pin and in from receive pin.
// - Control, test, status reachable directly and indexed; others indexed only.
// - Controller clock is the system clock.
// - Prescaler equals extension value plus one; extension resets to zero.
// - Time quantum equals clock period times prescaler.
// - Bit is sync, propagation, phase one, phase two segments.
// - Segments are whole quanta; sync segment is one quantum.
// - Timing fields packed at weights 0x1000, 0x0100, 0x0040, low bits.
// - Each timing field holds its length minus one.
// - Bit timing register sits at index 0x03.
// - Command request write moves interface set to or from object.
// - Message handler registers are read only flags.
// - Bit timing writes need config change enable set.
// - Prescaler extension writes need test bit set.
// - Indexed space spans 128 sixteen-bit words.
`include "cbt_params.svh"
`timescale 1ns/10ps
`default_nettype none
module cbt_can_core
    import cbt_pkg::*;
#(
    parameter int NUM_OBJ = 32
)(
    input  wire logic            mclk,         // System clock, 50 MHz
    input  wire logic            reset,        // Async reset, active high
    input  wire logic            idxAddrWr,    // Write index address
    input  wire cbt_pkg::cbt_index_t idxAddrIn, // Index value
    input  wire logic            dataHighWr,   // Write data high byte
    input  wire logic            dataLowWr,    // Write low byte, commits word
    input  wire logic            dataLowRd,    // Read strobe of low byte
    input  wire logic [7:0]      dataIn,       // Byte write data
    input  wire logic            directWr,     // Direct register write
    input  wire logic [1:0]      directSel,    // Direct register select
    input  wire logic [7:0]      directIn,     // Direct write data
    input  wire logic            busReceivePin, // Bus receive pin
    output logic                 busTransmitPin, // Bus transmit pin
    output cbt_pkg::cbt_index_t  indexAddressReg, // Current index
    output logic [7:0]           indexDataHigh, // Read data high byte
    output logic [7:0]           indexDataLow,  // Read data low byte
    output logic [7:0]           directOut,     // Direct read data
    output logic                 initActive     // Init bit state
);
    cbt_word_t  ctl_reg, ctl_next, bt_reg, bt_next, bre_reg, bre_next;
    cbt_word_t  sta_reg, sta_next, tst_reg, tst_next, rd_next;
    cbt_index_t idx_reg, idx_next;
    logic [7:0] hi_reg, hi_next, dOut_reg, dOut_next;
    logic [NUM_OBJ-1:0] val_reg, val_next, nd_reg, nd_next, txr_reg, txr_next;
    cbt_word_t  objRam [NUM_OBJ];
    cbt_word_t  ifData [2];
    logic [7:0] ifMask [2];
    logic       tx_reg, tx_next, rxBit;
    logic [15:0] shift_reg, shift_next;
    logic [4:0]  bitCnt_reg, bitCnt_next;
    logic        samplePt, bitEnd;
    logic        wrWord, ramWr, ramSet;
    logic [4:0]  ramObj;
    cbt_word_t   ramWdata, wWord;

    function automatic cbt_word_t flagHalf(input logic [NUM_OBJ-1:0] f, input logic hi);
        flagHalf = hi ? 16'(f >> 16) : 16'(f);
    endfunction

    assign wWord  = {hi_reg, dataIn};
    assign wrWord = dataLowWr;

    // ***********************************************
    // Register file and index access
    // ***********************************************
    always_comb begin
        ctl_next = ctl_reg; bt_next = bt_reg; bre_next = bre_reg;
        sta_next = sta_reg; tst_next = tst_reg; idx_next = idx_reg;
        hi_next  = dataHighWr ? dataIn : hi_reg;
        val_next = val_reg; nd_next = nd_reg; txr_next = txr_reg;
        ramWr = 1'b0; ramSet = 1'b0; ramObj = 5'h00; ramWdata = 16'h0000;
        rd_next = 16'h0000;
        if (idxAddrWr) begin
            idx_next = idxAddrIn;
        end
        case (idx_reg)
            `CBT_IDX_CONTROL:    rd_next = ctl_reg;
            `CBT_IDX_STATUS:     rd_next = sta_reg;
            `CBT_IDX_BIT_TIMING: rd_next = bt_reg;
            `CBT_IDX_TEST:       rd_next = tst_reg;
            `CBT_IDX_PRESC_EXT:  rd_next = bre_reg;
            `CBT_IDX_SET1_CMDREQ: rd_next = ifData[0];
            `CBT_IDX_SET2_CMDREQ: rd_next = ifData[1];
            `CBT_IDX_VALID_LO:   rd_next = flagHalf(val_reg, 1'b0);
            `CBT_IDX_VALID_HI:   rd_next = flagHalf(val_reg, 1'b1);
            `CBT_IDX_NEWDAT_LO:  rd_next = flagHalf(nd_reg, 1'b0);
            `CBT_IDX_NEWDAT_HI:  rd_next = flagHalf(nd_reg, 1'b1);
            `CBT_IDX_TXREQ_LO:   rd_next = flagHalf(txr_reg, 1'b0);
            `CBT_IDX_TXREQ_HI:   rd_next = flagHalf(txr_reg, 1'b1);
            default:             rd_next = 16'h0000;
        endcase
        if (wrWord) begin
            case (idx_reg)
                `CBT_IDX_CONTROL: ctl_next = wWord;
                `CBT_IDX_TEST:    tst_next = wWord;
                `CBT_IDX_BIT_TIMING: if (ctl_reg[`CBT_CTL_CFGEN]) bt_next = wWord;
                `CBT_IDX_PRESC_EXT:  if (ctl_reg[`CBT_CTL_TEST]) bre_next = {6'h00, wWord[9:0]};
                `CBT_IDX_SET1_CMDREQ, `CBT_IDX_SET2_CMDREQ: begin
                    ramObj = wWord[4:0];
                    if (ifMask[idx_reg == `CBT_IDX_SET2_CMDREQ][7]) begin
                        ramWr    = 1'b1;
                        ramWdata = ifData[idx_reg == `CBT_IDX_SET2_CMDREQ];
                        val_next[ramObj] = ifMask[idx_reg == `CBT_IDX_SET2_CMDREQ][0];
                        txr_next[ramObj] = ifMask[idx_reg == `CBT_IDX_SET2_CMDREQ][1];
                    end else begin
                        ramSet = 1'b1;
                        nd_next[ramObj] = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // direct access to control, status, test
        if (directWr) begin
            case (directSel)
                `CBT_DIR_CONTROL: ctl_next = {ctl_reg[15:8], directIn};
                `CBT_DIR_STATUS:  sta_next = {sta_reg[15:8], directIn};
                `CBT_DIR_TEST:    tst_next = {tst_reg[15:8], directIn};
                default: ;
            endcase
        end
        case (directSel)
            `CBT_DIR_CONTROL: dOut_next = ctl_next[7:0];
            `CBT_DIR_STATUS:  dOut_next = sta_next[7:0];
            `CBT_DIR_TEST:    dOut_next = tst_next[7:0];
            default:          dOut_next = 8'h00;
        endcase
        // Transmit done and receive complete update handler flags
        if (bitEnd && bitCnt_reg == 5'h0f) begin
            sta_next[3] = 1'b1;
            nd_next[0]  = 1'b1;
        end
        tst_next[`CBT_TST_RX] = busReceivePin;
    end

    // ***********************************************
    // Message RAM and interface sets
    // ***********************************************
    // object storage
    always_ff @(posedge mclk) begin
        if (ramWr) begin
            objRam[ramObj] <= ramWdata;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ifData[0] <= 16'h0000; ifData[1] <= 16'h0000;
            ifMask[0] <= 8'h00;    ifMask[1] <= 8'h00;
        end else begin
            if (ramSet) ifData[idx_reg == `CBT_IDX_SET2_CMDREQ] <= objRam[ramObj];
            if (wrWord && idx_reg == `CBT_IDX_SET1_CMDREQ + 7'h1) ifMask[0] <= dataIn;
            if (wrWord && idx_reg == `CBT_IDX_SET2_CMDREQ + 7'h1) ifMask[1] <= dataIn;
            if (wrWord && idx_reg == `CBT_IDX_SET1_CMDREQ + 7'h7) ifData[0] <= wWord;
            if (wrWord && idx_reg == `CBT_IDX_SET2_CMDREQ + 7'h7) ifData[1] <= wWord;
        end
    end

    // ***********************************************
    // Bit timing and shifter
    // ***********************************************
    // runs on system clock; halted during init
    cbt_bit_timer u_timer (
        .mclk        (mclk),
        .reset       (reset),
        .runEn       (!ctl_reg[`CBT_CTL_INIT]),
        .baudPrescM1 (bre_reg[9:0]),   // extension plus one
        .segOneM1    (bt_reg[`CBT_BT_SEGONE_LSB +: 4]),
        .segTwoM1    (bt_reg[`CBT_BT_SEGTWO_LSB +: 3]),
        .tqTick      (),
        .samplePt    (samplePt),
        .bitEnd      (bitEnd)
    );

    assign rxBit = busReceivePin;
    always_comb begin
        shift_next  = shift_reg;
        bitCnt_next = bitCnt_reg;
        tx_next     = tx_reg;
        if (ctl_reg[`CBT_CTL_INIT]) begin
            tx_next = 1'b1;
            bitCnt_next = 5'h00;
            shift_next = objRam[0];
        end else begin
            if (samplePt) shift_next = {shift_reg[14:0], rxBit};
            if (bitEnd) begin
                tx_next = txr_reg[0] ? shift_reg[15] : 1'b1;
                bitCnt_next = 5'(bitCnt_reg + 5'h01);
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctl_reg <= `CBT_RST_CONTROL; bt_reg <= `CBT_RST_BIT_TIMING;
            bre_reg <= `CBT_RST_PRESC_EXT; sta_reg <= 16'h0000;
            tst_reg <= `CBT_RST_TEST; idx_reg <= 7'h00; hi_reg <= 8'h00;
            val_reg <= '0; nd_reg <= '0; txr_reg <= '0;
            tx_reg <= 1'b1; shift_reg <= 16'h0000; bitCnt_reg <= 5'h00;
            indexDataHigh <= 8'h00; indexDataLow <= 8'h00; dOut_reg <= 8'h00;
        end else begin
            ctl_reg <= ctl_next; bt_reg <= bt_next; bre_reg <= bre_next;
            sta_reg <= sta_next; tst_reg <= tst_next; idx_reg <= idx_next;
            hi_reg <= hi_next; val_reg <= val_next; nd_reg <= nd_next;
            txr_reg <= txr_next; tx_reg <= tx_next; shift_reg <= shift_next;
            bitCnt_reg <= bitCnt_next;
            indexDataHigh <= rd_next[15:8]; indexDataLow <= rd_next[7:0];
            dOut_reg <= dOut_next;
        end
    end

    assign busTransmitPin  = tx_reg;
    assign indexAddressReg = idx_reg;
    assign directOut       = dOut_reg;
    assign initActive      = ctl_reg[`CBT_CTL_INIT];

    // ***********************************************
    // Checks
    // ***********************************************
    chk_bt_write_gate: assert property (@(posedge mclk) disable iff (reset)
        (wrWord && idx_reg == `CBT_IDX_BIT_TIMING && !ctl_reg[`CBT_CTL_CFGEN])
        |=> $stable(bt_reg))
        else $error("bit timing changed without enable");
    chk_bt_write_take: assert property (@(posedge mclk) disable iff (reset)
        (wrWord && idx_reg == `CBT_IDX_BIT_TIMING && ctl_reg[`CBT_CTL_CFGEN])
        |=> bt_reg == $past(wWord))
        else $error("bit timing write lost");
    chk_ext_gate: assert property (@(posedge mclk) disable iff (reset)
        (wrWord && idx_reg == `CBT_IDX_PRESC_EXT && !ctl_reg[`CBT_CTL_TEST]) |=> $stable(bre_reg))
        else $error("extension changed without test bit");
    chk_idle_init: assert property (@(posedge mclk) disable iff (reset)
        initActive |=> busTransmitPin)
        else $error("transmit active during init");
    chk_flags_ro: assert property (@(posedge mclk) disable iff (reset)
        (wrWord && idx_reg == `CBT_IDX_VALID_LO && !samplePt && !bitEnd) |=> $stable(val_reg))
        else $error("handler flags written");
    chk_direct_ctl: assert property (@(posedge mclk) disable iff (reset)
        (directWr && directSel == `CBT_DIR_CONTROL && !wrWord) |=> ctl_reg[7:0] == $past(directIn))
        else $error("direct control write lost");
    chk_cmd_xfer: assert property (@(posedge mclk) disable iff (reset)
        (ramWr) |=> objRam[$past(ramObj)] == $past(ramWdata))
        else $error("object transfer lost");
    chk_ext_reset: assert property (@(posedge mclk)
        $fell(reset) |-> bre_reg == 16'h0000)
        else $error("extension not zero after reset");
    cov_bt_write: cover property (@(posedge mclk) wrWord && idx_reg == `CBT_IDX_BIT_TIMING);
    cov_init_clear: cover property (@(posedge mclk) $fell(initActive));
    cov_bit_end: cover property (@(posedge mclk) bitEnd);
endmodule
`default_nettype wire

/* tb/cbt_bus_partner.sv */
// Purpose : Bus side of the controller: transceiver loop and wired bus level
// Assumes : One other node on the bus, recessive level is 1
// Notes   : Receive pin echoes the bus after the loop delay
`timescale 1ns/10ps
`default_nettype none
module cbt_bus_partner #(
    parameter int LOOP_DLY = 4
)(
    input  wire logic mclk,   // System clock
    input  wire logic txIn,   // Device transmit pin
    input  wire logic domReq, // Partner forces dominant
    output logic      rxOut   // Device receive pin
);
    logic [LOOP_DLY-1:0] pipeReg = '1;

    always_ff @(posedge mclk) begin
        pipeReg <= {pipeReg[LOOP_DLY-2:0], txIn & ~domReq};
    end
    assign rxOut = pipeReg[LOOP_DLY-1];
endmodule
`default_nettype wire

/* tb/can_controller_setup_and_bit_timing_test.sv */
// Purpose : Self-checking bench of the CAN setup and bit timing block
// Assumes : Core strobes are one-cycle pulses driven after the clock edge
// Notes   : Bit period is checked on the transmit pin with prescaler 2
`timescale 1ns/10ps
`default_nettype none
module can_controller_setup_and_bit_timing_test;
    import cbt_pkg::*;
    localparam int BIT_CYC = 2 * (1 + 15 + 6);
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       idxAddrWr = 1'b0;
    cbt_index_t idxAddrIn = 7'h00;
    logic       dataHighWr = 1'b0;
    logic       dataLowWr = 1'b0;
    logic       dataLowRd = 1'b0;
    logic [7:0] dataIn = 8'h00;
    logic       directWr = 1'b0;
    logic [1:0] directSel = 2'h0;
    logic [7:0] directIn = 8'h00;
    logic       busReceivePin;
    logic       busTransmitPin;
    logic [7:0] indexDataHigh;
    logic [7:0] indexDataLow;
    logic [7:0] directOut;
    logic       initActive;
    cbt_index_t idxOut;
    int         error_cnt = 0;
    int         check_count = 0;
    int         cycCnt = 0;
    int         lastEdge = -1;
    int         edgeCnt = 0;
    logic       txPrev = 1'b1;
    cbt_word_t  rdWord;

    cbt_can_core u_cbt_can_core (.mclk(mclk), .reset(reset), .idxAddrWr(idxAddrWr),
        .idxAddrIn(idxAddrIn), .dataHighWr(dataHighWr), .dataLowWr(dataLowWr),
        .dataLowRd(dataLowRd), .dataIn(dataIn), .directWr(directWr), .directSel(directSel),
        .directIn(directIn), .busReceivePin(busReceivePin), .busTransmitPin(busTransmitPin),
        .indexAddressReg(idxOut), .indexDataHigh(indexDataHigh), .indexDataLow(indexDataLow),
        .directOut(directOut), .initActive(initActive));
    cbt_bus_partner u_cbt_bus_partner (.mclk(mclk), .txIn(busTransmitPin), .domReq(1'b0),
        .rxOut(busReceivePin));

    always #10 mclk = ~mclk;

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string n, input cbt_word_t e, input cbt_word_t g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h got %h", n, e, g);
        end
    endtask

    task automatic wr_word(input cbt_index_t i, input cbt_word_t w);
        tick();
        idxAddrWr = 1'b1;
        idxAddrIn = i;
        tick();
        idxAddrWr = 1'b0;
        dataHighWr = 1'b1;
        dataIn = w[15:8];
        tick();
        dataHighWr = 1'b0;
        dataLowWr = 1'b1;
        dataIn = w[7:0];
        tick();
        dataLowWr = 1'b0;
    endtask

    task automatic rd_word(input cbt_index_t i, output cbt_word_t w);
        tick();
        idxAddrWr = 1'b1;
        idxAddrIn = i;
        tick();
        idxAddrWr = 1'b0;
        dataLowRd = 1'b1;
        tick();
        dataLowRd = 1'b0;
        tick();
        w = {indexDataHigh, indexDataLow};
    endtask

    task automatic rd_chk(input string n, input cbt_index_t i, input cbt_word_t e);
        cbt_word_t w;
        rd_word(i, w);
        chk(n, e, w);
    endtask

    task automatic dir_wr(input logic [1:0] s, input logic [7:0] v);
        tick();
        directWr = 1'b1;
        directSel = s;
        directIn = v;
        tick();
        directWr = 1'b0;
    endtask

    task automatic test_done(input string n);
        $display("Test %s finished", n);
    endtask

    task automatic final_report();
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard and transmit pin watcher, sampled away from the active edge
    always @(negedge mclk) begin
        cycCnt++;
        if (cycCnt == 20000) begin
            error_cnt++;
            final_report();
        end
        if (!reset && busTransmitPin !== txPrev) begin
            chk("init clear at tx edge", 16'h0000, {15'h0000, initActive});
            if (lastEdge >= 0)
                chk("bit spacing", 16'h0000, 16'((cycCnt - lastEdge) % BIT_CYC));
            lastEdge = cycCnt;
            edgeCnt++;
        end
        txPrev = busTransmitPin;
    end

    initial begin
        repeat (10) @(posedge mclk);
        #1;
        reset = 1'b0;
        rd_chk("control", 7'h00, 16'h0001);
        rd_chk("bit timing", 7'h03, 16'h2301);
        rd_chk("prescaler ext", 7'h06, 16'h0000);
        tick();
        directSel = 2'h0;
        tick();
        tick();
        chk("direct control", 16'h0001, {8'h00, directOut});
        test_done("reset values");
        wr_word(7'h03, 16'h5ec0);
        rd_chk("bit timing locked", 7'h03, 16'h2301);
        dir_wr(2'h0, 8'h41);
        wr_word(7'h03, 16'h5ec0);
        rd_chk("bit timing", 7'h03, 16'h5ec0);
        rd_chk("control", 7'h00, 16'h0041);
        test_done("timing setup");
        wr_word(7'h06, 16'h0001);
        rd_chk("ext locked", 7'h06, 16'h0000);
        dir_wr(2'h0, 8'hc1);
        wr_word(7'h06, 16'h0001);
        rd_chk("prescaler ext", 7'h06, 16'h0001);
        chk("index address", 16'h0006, {9'h000, idxOut});
        dir_wr(2'h0, 8'h41);
        test_done("prescaler");
        wr_word(7'h30, 16'hffff);
        rd_chk("valid flags read only", 7'h30, 16'h0000);
        wr_word(7'h0f, 16'h00a5);
        wr_word(7'h09, 16'h0083);
        wr_word(7'h08, 16'h0000);
        wr_word(7'h27, 16'h5a00);
        wr_word(7'h21, 16'h0081);
        wr_word(7'h20, 16'h001f);
        rd_word(7'h30, rdWord);
        chk("object 0 valid", 16'h0001, rdWord & 16'h0001);
        rd_word(7'h31, rdWord);
        chk("object 31 valid", 16'h8000, rdWord & 16'h8000);
        wr_word(7'h21, 16'h0000);
        wr_word(7'h20, 16'h0000);
        rd_chk("object read back", 7'h20, 16'h00a5);
        test_done("message objects");
        dir_wr(2'h0, 8'h00);
        for (int n = 0; n < 4000 && edgeCnt < 8; n++)
            tick();
        chk("init bit", 16'h0000, {15'h0000, initActive});
        chk("tx activity", 16'h0001, {15'h0000, edgeCnt > 0});
        test_done("transmission");
        final_report();
    end
endmodule
`default_nettype wire
